// *** bhj_pkg.sv ***
// What this block does
// - Three-bit field picks full-current headroom target, 210 mV up to 300 mV.
// - Three-bit field picks minimum headroom target, 50 mV up to 260 mV.
// - Two-bit field sets mid comparator offset above low threshold, from 200 mV.
// - Two-bit field sets horizontal range fraction: 1, 25, 37.5 or 50 percent.
// - Jump enable set allows upward boost jumps; cleared disables jumping entirely.
// - Jump trigger percentage: 6.25, 12.5, 25 or 50 percent brightness rise.
// - Jump size is 195, 390, 585 or 780 steps of about 10.26 mV.
// - Jump adds its step outside the adaptive headroom loop's own regulation.
// - With backlight, adaptive and jump enable on, brightness rising more than the threshold at once commands an immediate jump.
// - After a jump the requested boost voltage is clamped to the ceiling.
// - Default configuration takes brightness from the PWM input duty cycle.
// - Host switches backlight and configuration over I2C; writes accepted while off.
// - Default configuration drives 25 mA per LED string.
// - Default configuration supports twelve strings with a 28 V boost ceiling.
// - Ceiling select gives 18 V, 22 V, 25 V or 28 V.
// - Adaptive off holds initial target; adaptive on varies from 7 V to ceiling.
package bhj_pkg;
	// Register addresses on the serial link.
	localparam logic [7:0] BHJ_ADDR_COMMAND = 8'h00;
	localparam logic [7:0] BHJ_ADDR_BOOST = 8'h16;
	localparam logic [7:0] BHJ_ADDR_HR0 = 8'h78;
	localparam logic [7:0] BHJ_ADDR_HR1 = 8'h79;
	localparam logic [7:0] BHJ_ADDR_JUMP = 8'h7a;
	// Reset values.
	localparam logic [7:0] BHJ_RST_COMMAND = 8'h00;
	localparam logic [7:0] BHJ_RST_BOOST = 8'hf8;
	localparam logic [7:0] BHJ_RST_HR0 = 8'h00;
	localparam logic [7:0] BHJ_RST_HR1 = 8'h00;
	localparam logic [7:0] BHJ_RST_JUMP = 8'h00;
	// Writable bits; everything else is reserved and reads zero.
	localparam logic [7:0] BHJ_MASK_COMMAND = 8'h01;
	localparam logic [7:0] BHJ_MASK_BOOST = 8'hff;
	localparam logic [7:0] BHJ_MASK_HR0 = 8'h77;
	localparam logic [7:0] BHJ_MASK_HR1 = 8'h33;
	localparam logic [7:0] BHJ_MASK_JUMP = 8'h8f;
	// Field positions.
	localparam int BHJ_ON_BIT = 0;
	localparam int BHJ_CEIL_LSB = 6;
	localparam int BHJ_HEADROOM_TRACKING_ENABLE_BIT = 5;
	localparam int BHJ_INIT_LSB = 0;
	localparam int BHJ_SLOPE_LSB = 4;
	localparam int BHJ_VERT_LSB = 0;
	localparam int BHJ_HYST_LSB = 4;
	localparam int BHJ_HORZ_LSB = 0;
	localparam int BHJ_JEN_BIT = 7;
	localparam int BHJ_JUMP_TRIGGER_PERCENTAGE_LSB = 2;
	localparam int BHJ_JSIZE_LSB = 0;
	// Decoded analog targets in mV, and range in tenths of a percent.
	localparam logic [8:0] BHJ_FULL_MV [8] = '{9'd210, 9'd223, 9'd235, 9'd248,
		9'd260, 9'd273, 9'd285, 9'd300};
	localparam logic [8:0] BHJ_MIN_MV [8] = '{9'd50, 9'd80, 9'd110, 9'd140,
		9'd170, 9'd200, 9'd230, 9'd260};
	localparam logic [9:0] BHJ_HYST_MV [4] = '{10'd200, 10'd233, 10'd466, 10'd600};
	localparam logic [9:0] BHJ_RANGE_PERMILLE [4] = '{10'd10, 10'd250, 10'd375, 10'd500};
	// Boost voltage in steps of 10.26 mV (10260 uV).
	localparam int BHJ_STEP_UV = 10260;
	localparam int BHJ_FLOOR_MV = 7000;
	localparam int BHJ_TOP_MV = 28000;
	localparam int BHJ_INIT_CODES = 31;
	localparam logic [11:0] BHJ_FLOOR_STEPS = 12'((BHJ_FLOOR_MV * 1000) / BHJ_STEP_UV);
	localparam logic [11:0] BHJ_INIT_INC = 12'(((BHJ_TOP_MV - BHJ_FLOOR_MV) * 1000) /
		(BHJ_INIT_CODES * BHJ_STEP_UV));
	localparam logic [11:0] BHJ_CEIL_STEPS [4] = '{12'((18000 * 1000) / BHJ_STEP_UV),
		12'((22000 * 1000) / BHJ_STEP_UV), 12'((25000 * 1000) / BHJ_STEP_UV),
		12'((BHJ_TOP_MV * 1000) / BHJ_STEP_UV)};
	localparam logic [11:0] BHJ_JUMP_UNIT = 12'd195;
	// Default string setup.
	localparam logic [5:0] BHJ_STRING_MA = 6'd25;
	localparam logic [3:0] BHJ_STRING_COUNT = 4'd12;
	// Serial slave states.
	typedef enum logic [6:0] {
		BHJ_SL_IDLE = 7'h01,
		BHJ_SL_ADDR = 7'h02,
		BHJ_SL_ACK = 7'h04,
		BHJ_SL_PTR = 7'h08,
		BHJ_SL_WR = 7'h10,
		BHJ_SL_RD = 7'h20,
		BHJ_SL_RACK = 7'h40
	} bhj_slave_e;
	localparam logic [6:0] BHJ_SLAVE_ID = 7'h2c;
	localparam logic [3:0] BHJ_BYTE_BITS = 4'd8;
endpackage : bhj_pkg

// *** bhj_serial_slave.sv ***
`timescale 1ns/10ps
module bhj_serial_slave #(
	parameter logic [6:0] SLAVE_ID = bhj_pkg::BHJ_SLAVE_ID
) (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// Serial pins, open drain data.
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// Register access.
	output logic o_wr_pulse,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	input wire logic [7:0] i_rdata
);
	bhj_pkg::bhj_slave_e state;
	logic scl_q, sda_q, rw, acked, id_ok, data_ack;
	logic [7:0] shift;
	logic [3:0] cnt;
	wire scl_rise = i_scl & ~scl_q;
	wire scl_fall = ~i_scl & scl_q;
	wire start = i_scl & scl_q & sda_q & ~i_sda;
	wire stop = i_scl & scl_q & ~sda_q & i_sda;
	wire byte_done = (cnt == bhj_pkg::BHJ_BYTE_BITS);
	wire receiving = (state == bhj_pkg::BHJ_SL_ADDR) | (state == bhj_pkg::BHJ_SL_PTR) |
		(state == bhj_pkg::BHJ_SL_WR);

	// Edge history for the pins; inputs are already synchronous.
	always_ff @(posedge i_clk_sys) begin
		scl_q <= i_i2c_hold(i_sys_rst, i_scl);
		sda_q <= i_i2c_hold(i_sys_rst, i_sda);
	end

	function automatic logic i_i2c_hold(input logic rst, input logic v);
		i_i2c_hold = rst | v;
	endfunction : i_i2c_hold

	// Byte engine; data changes only while the clock is low, so the ack is placed on a fall.
	always_ff @(posedge i_clk_sys) begin
		o_wr_pulse <= 1'b0;
		o_sda_out <= 1'b0;
		if (i_sys_rst) begin
			state <= bhj_pkg::BHJ_SL_IDLE;
			o_sda_oe <= 1'b0;
			o_addr <= 8'h00;
			o_wdata <= 8'h00;
			shift <= 8'h00;
			cnt <= 4'h0;
			rw <= 1'b0;
			acked <= 1'b0;
			id_ok <= 1'b0;
			data_ack <= 1'b0;
		end else if (start) begin
			state <= bhj_pkg::BHJ_SL_ADDR;
			cnt <= 4'h0;
			o_sda_oe <= 1'b0;
		end else if (stop) begin
			state <= bhj_pkg::BHJ_SL_IDLE;
			o_sda_oe <= 1'b0;
		end else if (scl_rise) begin
			if (receiving) begin
				shift <= {shift[6:0], i_sda};
				cnt <= cnt + 4'h1;
			end else if (state == bhj_pkg::BHJ_SL_RD) begin
				cnt <= cnt + 4'h1;
			end else if (state == bhj_pkg::BHJ_SL_RACK) begin
				acked <= ~i_sda;
			end
		end else if (scl_fall) begin
			case (state)
				bhj_pkg::BHJ_SL_ADDR: begin
					if (byte_done) begin
						id_ok <= (shift[7:1] == SLAVE_ID);
						rw <= shift[0];
						o_sda_oe <= (shift[7:1] == SLAVE_ID);
						state <= (shift[7:1] == SLAVE_ID) ? bhj_pkg::BHJ_SL_ACK :
							bhj_pkg::BHJ_SL_IDLE;
					end
				end
				bhj_pkg::BHJ_SL_PTR: begin
					if (byte_done) begin
						o_addr <= shift; // Writes are taken whether or not the light is on.
						data_ack <= 1'b0;
						o_sda_oe <= 1'b1;
						state <= bhj_pkg::BHJ_SL_ACK;
					end
				end
				bhj_pkg::BHJ_SL_WR: begin
					if (byte_done) begin
						o_wdata <= shift;
						o_wr_pulse <= 1'b1;
						data_ack <= 1'b1;
						o_sda_oe <= 1'b1;
						state <= bhj_pkg::BHJ_SL_ACK;
					end
				end
				bhj_pkg::BHJ_SL_ACK: begin
					cnt <= 4'h0;
					if (rw) begin
						shift <= i_rdata;
						o_sda_oe <= ~i_rdata[7];
						state <= bhj_pkg::BHJ_SL_RD;
					end else begin
						o_sda_oe <= 1'b0;
						if (id_ok) begin
							state <= bhj_pkg::BHJ_SL_PTR;
						end else begin
							state <= bhj_pkg::BHJ_SL_WR;
							// The pointer moves on only after a data byte, never after the pointer byte.
							if (data_ack)
								o_addr <= o_addr + 8'h01;
						end
						id_ok <= 1'b0;
					end
				end
				bhj_pkg::BHJ_SL_RD: begin
					if (byte_done) begin
						o_sda_oe <= 1'b0;
						o_addr <= o_addr + 8'h01;
						state <= bhj_pkg::BHJ_SL_RACK;
					end else begin
						shift <= {shift[6:0], 1'b0};
						o_sda_oe <= ~shift[6];
					end
				end
				bhj_pkg::BHJ_SL_RACK: begin
					cnt <= 4'h0;
					shift <= i_rdata;
					o_sda_oe <= acked & ~i_rdata[7];
					state <= acked ? bhj_pkg::BHJ_SL_RD : bhj_pkg::BHJ_SL_IDLE;
				end
				default: begin
					o_sda_oe <= 1'b0;
				end
			endcase
		end
	end
endmodule : bhj_serial_slave

// *** bhj_headroom_jump.sv ***
`timescale 1ns/10ps
module bhj_headroom_jump #(
	parameter int BRT_W = 12,
	parameter logic [6:0] SLAVE_ID = bhj_pkg::BHJ_SLAVE_ID
) (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// Serial register port.
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// Brightness from the PWM duty decoder.
	input wire logic [BRT_W-1:0] i_pwm_duty,
	// Adaptive loop step requests, one-cycle pulses.
	input wire logic i_loop_raise,
	input wire logic i_loop_lower,
	// Boost and headroom targets.
	output logic [11:0] o_boost_target,
	output logic o_jump_pulse,
	output logic o_backlight_on,
	output logic [8:0] o_headroom_at_full_current_mv,
	output logic [8:0] o_minimum_headroom_level_mv,
	output logic [9:0] o_mid_comparator_offset_mv,
	output logic [9:0] o_headroom_range_fraction_permille,
	// Default string setup.
	output logic [5:0] o_string_current_ma,
	output logic [3:0] o_string_count
);
	logic [7:0] reg_command, reg_boost, headroom_curve_primary;
	logic [7:0] headroom_curve_secondary, boost_voltage_jump_control;
	logic [BRT_W-1:0] brt_q;
	logic wr_pulse;
	logic [7:0] bus_addr, bus_wdata;
	logic [7:0] next_rdata;

	bhj_serial_slave #(
		.SLAVE_ID(SLAVE_ID)
	) u_slave (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.o_sda_out(o_sda_out),
		.o_sda_oe(o_sda_oe),
		.o_wr_pulse(wr_pulse),
		.o_addr(bus_addr),
		.o_wdata(bus_wdata),
		.i_rdata(next_rdata)
	);

	// Address decode; reserved bits are masked off on the way in, so they read back zero.
	wire sel_command = (bus_addr == bhj_pkg::BHJ_ADDR_COMMAND);
	wire sel_boost = (bus_addr == bhj_pkg::BHJ_ADDR_BOOST);
	wire sel_hr0 = (bus_addr == bhj_pkg::BHJ_ADDR_HR0);
	wire sel_hr1 = (bus_addr == bhj_pkg::BHJ_ADDR_HR1);
	wire sel_jump = (bus_addr == bhj_pkg::BHJ_ADDR_JUMP);
	assign next_rdata = sel_command ? reg_command :
		sel_boost ? reg_boost :
		sel_hr0 ? headroom_curve_primary :
		sel_hr1 ? headroom_curve_secondary :
		sel_jump ? boost_voltage_jump_control : 8'h00;

	// Register writes; configuration may change at any time, also before turning on.
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			reg_command <= bhj_pkg::BHJ_RST_COMMAND;
			reg_boost <= bhj_pkg::BHJ_RST_BOOST;
			headroom_curve_primary <= bhj_pkg::BHJ_RST_HR0;
			headroom_curve_secondary <= bhj_pkg::BHJ_RST_HR1;
			boost_voltage_jump_control <= bhj_pkg::BHJ_RST_JUMP;
		end else if (wr_pulse) begin
			if (sel_command)
				reg_command <= bus_wdata & bhj_pkg::BHJ_MASK_COMMAND;
			if (sel_boost)
				reg_boost <= bus_wdata & bhj_pkg::BHJ_MASK_BOOST;
			if (sel_hr0)
				headroom_curve_primary <= bus_wdata & bhj_pkg::BHJ_MASK_HR0;
			if (sel_hr1)
				headroom_curve_secondary <= bus_wdata & bhj_pkg::BHJ_MASK_HR1;
			if (sel_jump)
				boost_voltage_jump_control <= bus_wdata & bhj_pkg::BHJ_MASK_JUMP;
		end
	end

	// Field extraction.
	wire backlight_on = reg_command[bhj_pkg::BHJ_ON_BIT];
	wire [1:0] boost_ceiling_select = reg_boost[bhj_pkg::BHJ_CEIL_LSB +: 2];
	wire headroom_tracking_enable = reg_boost[bhj_pkg::BHJ_HEADROOM_TRACKING_ENABLE_BIT];
	wire [4:0] initial_boost_target = reg_boost[bhj_pkg::BHJ_INIT_LSB +: 5];
	wire [2:0] headroom_at_full_current = headroom_curve_primary[bhj_pkg::BHJ_SLOPE_LSB +: 3];
	wire [2:0] minimum_headroom_level = headroom_curve_primary[bhj_pkg::BHJ_VERT_LSB +: 3];
	wire [1:0] mid_comparator_offset = headroom_curve_secondary[bhj_pkg::BHJ_HYST_LSB +: 2];
	wire [1:0] headroom_range_fraction = headroom_curve_secondary[bhj_pkg::BHJ_HORZ_LSB +: 2];
	wire voltage_jump_enable = boost_voltage_jump_control[bhj_pkg::BHJ_JEN_BIT];
	wire [1:0] jump_trigger_percentage = boost_voltage_jump_control[bhj_pkg::BHJ_JUMP_TRIGGER_PERCENTAGE_LSB +: 2];
	wire [1:0] jump_step_count = boost_voltage_jump_control[bhj_pkg::BHJ_JSIZE_LSB +: 2];

	// Boost limits in voltage steps.
	wire [11:0] ceil_steps = bhj_pkg::BHJ_CEIL_STEPS[boost_ceiling_select];
	wire [11:0] init_steps = bhj_pkg::BHJ_FLOOR_STEPS +
		12'(initial_boost_target * bhj_pkg::BHJ_INIT_INC);
	wire [11:0] jump_steps = 12'(bhj_pkg::BHJ_JUMP_UNIT * ({1'b0, jump_step_count} + 3'd1));
	// The ceiling also caps a held initial target, so no request ever passes it.
	wire [11:0] init_clamped = (init_steps > ceil_steps) ? ceil_steps : init_steps;

	// Brightness rise detection; the threshold is a fraction of full scale, 1/16 up to 1/2.
	// Rise is measured sample to sample, so a slow ramp never trips it by design.
	wire [BRT_W-1:0] brightness = i_pwm_duty;
	wire rising = (brightness > brt_q);
	wire [BRT_W-1:0] rise_amount = rising ? (brightness - brt_q) : '0;
	wire [BRT_W:0] full_scale = (BRT_W+1)'(1) << BRT_W;
	wire [BRT_W:0] jump_threshold = full_scale >> (3'd4 - {1'b0, jump_trigger_percentage});
	wire jump_fire = backlight_on & headroom_tracking_enable & voltage_jump_enable &
		({1'b0, rise_amount} > jump_threshold);

	// Target arithmetic; the jump is applied on top of whatever the loop has reached.
	wire [12:0] jump_sum = {1'b0, o_boost_target} + {1'b0, jump_steps};
	wire [11:0] jump_clamped = (jump_sum > {1'b0, ceil_steps}) ? ceil_steps :
		jump_sum[11:0];
	wire can_raise = (o_boost_target < ceil_steps);
	wire can_lower = (o_boost_target > bhj_pkg::BHJ_FLOOR_STEPS);
	logic [11:0] next_target;
	always_comb begin
		next_target = o_boost_target;
		if (!backlight_on || !headroom_tracking_enable)
			next_target = init_clamped;
		else if (jump_fire)
			next_target = jump_clamped;
		else if (o_boost_target > ceil_steps)
			next_target = ceil_steps; // A lowered ceiling pulls the target down at once.
		else if (i_loop_raise && can_raise)
			next_target = o_boost_target + 12'h001;
		else if (i_loop_lower && can_lower)
			next_target = o_boost_target - 12'h001;
	end

	// Boost target and jump indication.
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_boost_target <= bhj_pkg::BHJ_FLOOR_STEPS;
			o_jump_pulse <= 1'b0;
			brt_q <= '0;
		end else begin
			o_boost_target <= next_target;
			o_jump_pulse <= jump_fire;
			brt_q <= brightness;
		end
	end

	// Decoded headroom settings for the analog loop, registered so outputs come from flops.
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_backlight_on <= 1'b0;
			o_headroom_at_full_current_mv <= bhj_pkg::BHJ_FULL_MV[0];
			o_minimum_headroom_level_mv <= bhj_pkg::BHJ_MIN_MV[0];
			o_mid_comparator_offset_mv <= bhj_pkg::BHJ_HYST_MV[0];
			o_headroom_range_fraction_permille <= bhj_pkg::BHJ_RANGE_PERMILLE[0];
			o_string_current_ma <= bhj_pkg::BHJ_STRING_MA;
			o_string_count <= bhj_pkg::BHJ_STRING_COUNT;
		end else begin
			o_backlight_on <= backlight_on;
			o_headroom_at_full_current_mv <= bhj_pkg::BHJ_FULL_MV[headroom_at_full_current];
			o_minimum_headroom_level_mv <= bhj_pkg::BHJ_MIN_MV[minimum_headroom_level];
			o_mid_comparator_offset_mv <= bhj_pkg::BHJ_HYST_MV[mid_comparator_offset];
			o_headroom_range_fraction_permille <=
				bhj_pkg::BHJ_RANGE_PERMILLE[headroom_range_fraction];
			o_string_current_ma <= bhj_pkg::BHJ_STRING_MA;
			o_string_count <= bhj_pkg::BHJ_STRING_COUNT;
		end
	end
endmodule : bhj_headroom_jump

// *** bhj_headroom_jump_assertions.sv ***
`timescale 1ns/10ps
// Port-level checks for the headroom tables and the boost jump path.
module bhj_headroom_jump_assertions #(
	parameter int BRT_W = 12
) (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// Watched inputs and outputs.
	input wire logic [BRT_W-1:0] i_pwm_duty,
	input wire logic o_sda_out,
	input wire logic [11:0] o_boost_target,
	input wire logic o_jump_pulse,
	input wire logic o_backlight_on,
	input wire logic [8:0] o_headroom_at_full_current_mv,
	input wire logic [8:0] o_minimum_headroom_level_mv,
	input wire logic [5:0] o_string_current_ma,
	input wire logic [3:0] o_string_count
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	// A jump pulse lasts one cycle unless a second large rise follows at once.
	sequence s_jump_seen;
		o_jump_pulse ##1 (!o_jump_pulse ||
			int'($past(i_pwm_duty)) > int'($past(i_pwm_duty, 2)) + 256);
	endsequence
	// The smallest trigger is a rise above 256 counts of duty.
	sequence s_big_rise;
		int'($past(i_pwm_duty)) > int'($past(i_pwm_duty, 2)) + 256;
	endsequence
	a_pulse_single: assert property (o_jump_pulse |-> s_jump_seen)
		else $error("jump pulse longer than one cycle");
	a_jump_needs_on: assert property (o_jump_pulse |-> o_backlight_on)
		else $error("jump while backlight off");
	a_jump_needs_rise: assert property (o_jump_pulse |-> s_big_rise)
		else $error("jump without a large rise");
	// A clamped jump lands on a ceiling, so its step may be shorter.
	a_jump_step_size: assert property (o_jump_pulse |->
		12'(o_boost_target - $past(o_boost_target)) inside {12'd195, 12'd390, 12'd585, 12'd780}
		|| o_boost_target inside {12'd1754, 12'd2144, 12'd2436, 12'd2729})
		else $error("jump step size wrong");
	a_jump_rises: assert property (o_jump_pulse |-> o_boost_target > $past(o_boost_target)
		|| o_boost_target inside {12'd1754, 12'd2144, 12'd2436, 12'd2729})
		else $error("jump did not raise target");
	a_target_range: assert property (o_boost_target inside {[12'd682:12'd2729]})
		else $error("boost target out of range");
	a_open_drain: assert property (o_sda_out == 1'b0)
		else $error("data pin driven high");
	a_string_setup: assert property (o_string_current_ma == 6'd25
		&& o_string_count == 4'd12)
		else $error("string setup wrong");
	a_full_range: assert property (o_headroom_at_full_current_mv inside {[9'd210:9'd300]})
		else $error("full current headroom out of range");
	a_min_range: assert property (o_minimum_headroom_level_mv inside {[9'd50:9'd260]})
		else $error("minimum headroom out of range");
endmodule : bhj_headroom_jump_assertions

bind bhj_headroom_jump bhj_headroom_jump_assertions #(.BRT_W(BRT_W)) chk_u (.i_clk_sys,
	.i_sys_rst, .i_pwm_duty, .o_sda_out, .o_boost_target, .o_jump_pulse, .o_backlight_on,
	.o_headroom_at_full_current_mv, .o_minimum_headroom_level_mv, .o_string_current_ma,
	.o_string_count);

// *** bhj_host_model.sv ***
`timescale 1ns/10ps
// Host on the serial register link; it releases data high, the pull-up does the rest.
module bhj_host_model #(
	parameter logic [6:0] ID = 7'h2c
) (
	// Clock and wire level.
	input wire logic i_clk_sys,
	input wire logic i_sda,
	// Driven pins, high means released.
	output logic o_scl,
	output logic o_sda
);
	// Idle bus: both lines released.
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// Four clocks per hold, clock high one hold and low two, keeps above the slave's three-clock minimum.
	task automatic hold();
		repeat (4) @(posedge i_clk_sys);
		#1;
	endtask : hold
	task automatic xfer_bit(input logic b, output logic seen);
		o_sda = b;
		hold();
		o_scl = 1'b1;
		hold();
		seen = i_sda;
		o_scl = 1'b0;
		hold();
	endtask : xfer_bit
	// The ninth bit is always released: the slave acks writes, the host naks reads.
	task automatic xfer_byte(input logic [7:0] d, output logic [7:0] q, output logic nak);
		for (int i = 7; i >= 0; i--) xfer_bit(d[i], q[i]);
		xfer_bit(1'b1, nak);
	endtask : xfer_byte
	task automatic start();
		o_sda = 1'b1;
		hold();
		o_scl = 1'b1;
		hold();
		o_sda = 1'b0;
		hold();
		o_scl = 1'b0;
		hold();
	endtask : start
	task automatic stop();
		o_sda = 1'b0;
		hold();
		o_scl = 1'b1;
		hold();
		o_sda = 1'b1;
		hold();
	endtask : stop
	// Configuration writes, usually made before the backlight is switched on.
	task automatic write_reg(input logic [6:0] id, input logic [7:0] a, input logic [7:0] d,
		output logic [2:0] nak);
		logic [7:0] q;
		start();
		xfer_byte({id, 1'b0}, q, nak[2]);
		xfer_byte(a, q, nak[1]);
		xfer_byte(d, q, nak[0]);
		stop();
	endtask : write_reg
	task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
		logic n;
		start();
		xfer_byte({ID, 1'b0}, q, n);
		xfer_byte(a, q, n);
		start();
		xfer_byte({ID, 1'b1}, q, n);
		xfer_byte(8'hff, q, n);
		stop();
	endtask : read_reg
endmodule : bhj_host_model

// *** bhj_headroom_jump_tb.sv ***
`timescale 1ns/10ps
// Register traffic goes through the host model; jumps are provoked through the duty input.
module bhj_headroom_jump_tb;
	localparam logic [11:0] CEIL [4] = '{12'd1754, 12'd2144, 12'd2436, 12'd2729};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] duty = 12'h000;
	logic raise = 1'b0;
	logic lower = 1'b0;
	logic [11:0] want = 12'd682;
	logic [2:0] nak;
	int fails = 0;
	int check_count = 0;
	wire logic scl, host_sda, sda_oe, sda_line, pls, bl_on;
	wire logic [11:0] tgt;
	wire logic [8:0] hr_full, hr_min;
	wire logic [9:0] hr_hyst, hr_rng;
	wire logic [5:0] s_ma;
	wire logic [3:0] s_n;
	// Open drain data: the line is low while either side pulls it.
	assign sda_line = host_sda & ~sda_oe;
	always #25 clk = ~clk;
	bhj_headroom_jump dut_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda_line),
		.o_sda_out(), .o_sda_oe(sda_oe), .i_pwm_duty(duty), .i_loop_raise(raise),
		.i_loop_lower(lower), .o_boost_target(tgt), .o_jump_pulse(pls), .o_backlight_on(bl_on),
		.o_headroom_at_full_current_mv(hr_full), .o_minimum_headroom_level_mv(hr_min),
		.o_mid_comparator_offset_mv(hr_hyst), .o_headroom_range_fraction_permille(hr_rng),
		.o_string_current_ma(s_ma), .o_string_count(s_n));
	bhj_host_model #(.ID(bhj_pkg::BHJ_SLAVE_ID)) host_u (.i_clk_sys(clk), .i_sda(sda_line),
		.o_scl(scl), .o_sda(host_sda));
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp_v);
		check_count++;
		if (seen !== exp_v) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp_v, seen);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : final_report
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.write_reg(bhj_pkg::BHJ_SLAVE_ID, a, d, nak);
		check("write ack", 16'(nak), 16'h0000);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp_v);
		logic [7:0] q;
		host_u.read_reg(a, q);
		check("read back", 16'(q), 16'(exp_v));
	endtask : rd
	// A zero step means no jump is expected; the target never passes the 28 V ceiling.
	task automatic jump_try(input logic [11:0] d, input logic [11:0] step);
		duty = 12'h000;
		tick(2);
		duty = d;
		tick(1);
		check("jump pulse", 16'(pls), 16'(step != 12'h000));
		want = (want + step > 12'd2729) ? 12'd2729 : want + step;
		check("jump target", 16'(tgt), 16'(want));
	endtask : jump_try
	task automatic loop_step(input logic r, input logic l, input logic [11:0] exp_v);
		raise = r;
		lower = l;
		tick(1);
		raise = 1'b0;
		lower = 1'b0;
		tick(1);
		check("loop target", 16'(tgt), 16'(exp_v));
	endtask : loop_step
	// A hung run still ends with a verdict.
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		final_report();
	end
	// Main sequence: reset values, tables, refusals, ceilings, jumps, loop steps.
	initial begin
		tick(12);
		rst = 1'b0;
		tick(2);
		check("init target", 16'(tgt), 16'd2266);
		check("string mA", 16'(s_ma), 16'd25);
		check("strings", 16'(s_n), 16'd12);
		rd(8'h00, 8'h00);
		rd(8'h16, 8'hf8);
		rd(8'h7a, 8'h00);
		for (int c = 0; c < 8; c++) begin
			wr(8'h78, {1'b1, 3'(c), 1'b1, 3'(c)});
			tick(2);
			check("full mV", 16'(hr_full), 16'(bhj_pkg::BHJ_FULL_MV[c]));
			check("min mV", 16'(hr_min), 16'(50 + 30 * c));
			rd(8'h78, {1'b0, 3'(c), 1'b0, 3'(c)});
		end
		for (int c = 0; c < 4; c++) begin
			wr(8'h79, {2'b11, 2'(c), 2'b11, 2'(c)});
			tick(2);
			check("offset mV", 16'(hr_hyst), 16'(bhj_pkg::BHJ_HYST_MV[c]));
			check("range", 16'(hr_rng), 16'(bhj_pkg::BHJ_RANGE_PERMILLE[c]));
			rd(8'h79, {2'b00, 2'(c), 2'b00, 2'(c)});
		end
		host_u.write_reg(bhj_pkg::BHJ_SLAVE_ID ^ 7'h01, 8'h7a, 8'hff, nak);
		check("foreign id", 16'(nak), 16'h0007);
		rd(8'h7a, 8'h00);
		wr(8'h50, 8'haa);
		rd(8'h50, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(8'h16, {2'(c), 6'h1f});
			tick(2);
			// Initial code 31 sits just under 28 V, so only the lower ceilings clip it.
			check("ceiling", 16'(tgt), 16'((CEIL[c] < 12'd2728) ? CEIL[c] : 12'd2728));
		end
		wr(8'h16, 8'he0);
		wr(8'h7a, 8'h0f);
		wr(8'h00, 8'h01);
		check("backlight", 16'(bl_on), 16'h0001);
		jump_try(12'hfff, 12'd0);
		for (int c = 0; c < 4; c++) begin
			wr(8'h7a, 8'h80 | 8'(c * 5));
			jump_try(12'(13'h1000 >> (4 - c)), 12'd0);
			jump_try(12'(13'h1000 >> (4 - c)) + 12'd1, 12'(195 * (c + 1)));
		end
		jump_try(12'hfff, 12'd780);
		loop_step(1'b1, 1'b0, 12'd2729);
		loop_step(1'b0, 1'b1, 12'd2728);
		loop_step(1'b1, 1'b1, 12'd2729);
		wr(8'h00, 8'h00);
		tick(2);
		check("off target", 16'(tgt), 16'd682);
		wr(8'h7a, 8'hff);
		rd(8'h7a, 8'h8f);
		final_report();
	end
endmodule : bhj_headroom_jump_tb
